// file: rtl/irsl_link_setup.sv
// irsl_link_setup: secondary-station connection state machine
// assumes a frame layer reports decoded frames and sends the reply asked for;
// the frame layer reports rx_busy while a frame is arriving
`timescale 1ns/1ps

module irsl_link_setup
    import irsl_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = IDLE_TIMEOUT_CYC,
    parameter logic [7:0]  LOCAL_RATES = RATE_CAP_MASK
)
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // decoded frames from the frame layer
    input  wire logic        rx_valid,
    input  wire logic [2:0]  rx_kind,
    input  wire logic [3:0]  rx_slot,
    input  wire logic [7:0]  rx_rate,
    input  wire logic [1:0]  rx_subject,
    input  wire logic        rx_busy,
    // reply request to the frame layer
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic      [2:0]  tx_kind,
    output logic      [7:0]  tx_rate,
    output logic      [7:0]  tx_turn,
    output logic      [7:0]  tx_window,
    output logic      [7:0]  tx_disc,
    output logic      [7:0]  tx_answer,
    // link state
    output logic      [7:0]  link_rate,
    output logic             connected,
    // host handshake, high inhibits the host
    output logic             cts
);
    localparam int unsigned TW = $clog2(TIMEOUT_CYC + 1);

    typedef struct packed {
        irsl_state_e state;
        logic        answered;
        logic        pending;
        logic [2:0]  kind;
        logic [7:0]  rate;
        logic [7:0]  offer;
        logic        rate_set;
        logic        ans_wait;
        logic [7:0]  peer;
        logic [1:0]  subject;
        logic [TW-1:0] idle;
    } irsl_st_s;

    irsl_st_s   st_reg;
    irsl_st_s   st_next;
    logic [7:0] rom_answer;

    // highest single rate bit of a mask
    function automatic logic [7:0] top_rate(input logic [7:0] m);
        logic [7:0] r;
        r = RATE_DEFAULT;
        for (int i = 0; i < 8; i++)
            if (m[i])
                r = 8'(1 << i);
        return r;
    endfunction

    // subject held in state: the frame fields are gone once rx_valid drops
    irsl_answer_rom irsl_answer_rom_i
    (
        .clock   (clock),
        .subject (st_reg.subject),
        .answer  (rom_answer)
    );

    always_comb
    begin
        st_next = st_reg;
        // hand the reply over; request stays until taken
        if (st_reg.pending && tx_ready && !rx_busy)
        begin
            st_next.pending = 1'b0;
            // close confirm goes out at the old rate, then back to default
            if (st_reg.state == ST_DISC_POLL)
                st_next.rate = RATE_DEFAULT;
        end
        if (st_reg.ans_wait)
        begin
            st_next.ans_wait = 1'b0;
            st_next.pending  = 1'b1;
            st_next.kind     = TX_ANSWER;
        end
        if (st_reg.state == ST_CONNECTED && st_reg.idle != '0)
            st_next.idle = st_reg.idle - TW'(1);
        case (st_reg.state)
            ST_DISC_POLL:
            begin
                if (rx_valid && rx_kind == RX_POLL)
                begin
                    if (rx_slot == 4'h0)
                        st_next.answered = 1'b0;
                    if (rx_slot == OUR_SLOT)
                    begin
                        st_next.pending  = 1'b1;
                        st_next.kind     = TX_SLOT;
                        st_next.answered = 1'b1;
                    end
                end
                if (rx_valid && rx_kind == RX_ID && st_reg.answered)
                    st_next.state = ST_LINK_INIT;
            end
            ST_LINK_INIT:
            begin
                if (rx_valid && rx_kind == RX_PARAM)
                begin
                    st_next.offer   = LOCAL_RATES & RATE_CAP_MASK;
                    st_next.peer    = rx_rate | RATE_DEFAULT;
                    st_next.pending = 1'b1;
                    st_next.kind    = TX_PARAM;
                    st_next.rate_set = 1'b1;
                    st_next.state   = ST_RESOURCE;
                end
            end
            ST_RESOURCE:
            begin
                // rate changes only once our parameter reply has gone out
                if (st_reg.rate_set && !st_reg.pending)
                begin
                    st_next.rate     = top_rate(st_reg.peer & st_reg.offer);
                    st_next.rate_set = 1'b0;
                end
                if (rx_valid && rx_kind == RX_QUERY)
                begin
                    st_next.ans_wait = 1'b1;
                    st_next.subject  = rx_subject;
                end
                if (rx_valid && rx_kind == RX_CONNECT)
                begin
                    st_next.state = ST_CONNECTED;
                    st_next.idle  = TW'(TIMEOUT_CYC);
                end
            end
            ST_CONNECTED:
            begin
                if (rx_valid)
                    st_next.idle = TW'(TIMEOUT_CYC);
                if (rx_valid && rx_kind == RX_CLOSE)
                begin
                    st_next.pending = 1'b1;
                    st_next.kind    = TX_CONFIRM;
                    st_next.state   = ST_DISC_POLL;
                end
                else if (rx_valid && rx_kind == RX_POLL)
                begin
                    st_next.pending = 1'b1;
                    st_next.kind    = TX_KEEP;
                end
                else if (!rx_valid && st_reg.idle == TW'(1))
                begin
                    st_next.state = ST_DISC_POLL;
                    st_next.rate  = RATE_DEFAULT;
                end
            end
            default: st_next.state = ST_DISC_POLL;
        endcase
        if (st_next.state == ST_DISC_POLL && st_reg.state != ST_DISC_POLL)
        begin
            st_next.answered = 1'b0;
            if (!st_next.pending)
                st_next.rate = RATE_DEFAULT;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            st_reg       <= '0;
            st_reg.state <= ST_DISC_POLL;
            st_reg.rate  <= RATE_DEFAULT;
            st_reg.offer <= RATE_DEFAULT;
            st_reg.peer  <= RATE_DEFAULT;
        end
        else
            st_reg <= st_next;
    end

    assign tx_valid  = st_reg.pending && !rx_busy;
    assign tx_kind   = st_reg.kind;
    assign tx_rate   = st_reg.offer;
    assign tx_turn   = PARAM_TURN;
    assign tx_window = PARAM_WINDOW;
    assign tx_disc   = PARAM_DISC;
    assign tx_answer = rom_answer;
    assign link_rate = st_reg.rate;
    assign connected = st_reg.state == ST_CONNECTED;
    assign cts       = st_reg.state != ST_CONNECTED;

    AST_HALF_DUPLEX: assert property (@(posedge clock) disable iff (rst)
        rx_busy |-> !tx_valid) else $error("reply offered while receiving");
    AST_SLOT_TWO: assert property (@(posedge clock) disable iff (rst)
        (st_reg.state == ST_DISC_POLL && rx_valid && rx_kind == RX_POLL && rx_slot == OUR_SLOT)
        |=> st_reg.pending && st_reg.kind == TX_SLOT) else $error("no answer in slot 2");
    AST_NO_OTHER_SLOT: assert property (@(posedge clock) disable iff (rst)
        (st_reg.state == ST_DISC_POLL && !st_reg.pending && rx_valid && rx_kind == RX_POLL
         && rx_slot != OUR_SLOT) |=> !st_reg.pending) else $error("answer in wrong slot");
    sequence s_answered;
        st_reg.answered;
    endsequence
    sequence s_ident;
        rx_valid && rx_kind == RX_ID && st_reg.state == ST_DISC_POLL;
    endsequence
    AST_DISCOVERY_ENTRY: assert property (@(posedge clock) disable iff (rst)
        (st_reg.state == ST_DISC_POLL ##1 st_reg.state == ST_LINK_INIT)
        |-> $past(st_reg.answered) && $past(rx_kind) == RX_ID) else $error("discovery without sequence");
    AST_DISCOVERY_GO: assert property (@(posedge clock) disable iff (rst)
        s_answered and s_ident |=> st_reg.state == ST_LINK_INIT) else $error("identification ignored");
    AST_RATE_CAP: assert property (@(posedge clock) disable iff (rst)
        (tx_valid && tx_kind == TX_PARAM) |-> !tx_rate[7] && !tx_rate[6]) else $error("rate offer too high");
    AST_CTS_HELD: assert property (@(posedge clock) disable iff (rst)
        st_reg.state != ST_CONNECTED |-> cts) else $error("host released early");
    AST_CTS_RELEASE: assert property (@(posedge clock) disable iff (rst)
        $fell(cts) |-> $past(st_reg.state == ST_RESOURCE && rx_valid && rx_kind == RX_CONNECT))
        else $error("host released without connect");
    AST_QUERY_ANSWER: assert property (@(posedge clock) disable iff (rst)
        (st_reg.state == ST_RESOURCE && rx_valid && rx_kind == RX_QUERY)
        |-> ##2 st_reg.pending && st_reg.kind == TX_ANSWER) else $error("query unanswered");
    AST_DEFAULT_RATE: assert property (@(posedge clock) disable iff (rst)
        (st_reg.state == ST_DISC_POLL && !st_reg.pending) |-> link_rate == RATE_DEFAULT)
        else $error("polling not at default rate");
    AST_MODEM: assert property (@(posedge clock) disable iff (rst)
        (tx_valid && tx_kind == TX_ANSWER && st_reg.subject == Q_CAPS) |-> tx_answer == CLASS_MODEM)
        else $error("class not modem");
endmodule

// file: rtl/irsl_pkg.sv
// irsl_pkg: constants for the secondary-station link setup controller
// assumes a 20 MHz clock and a frame layer that decodes and builds frames
package irsl_pkg;
    localparam int unsigned CLK_HZ          = 20000000;
    localparam int unsigned DEFAULT_BAUD    = 9600;
    localparam int unsigned MAX_BAUD        = 115200;
    localparam logic [3:0]  OUR_SLOT        = 4'h2;
    localparam int unsigned IDLE_TIMEOUT_S  = 10;
    localparam int unsigned IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_S * CLK_HZ;
    // rate capability bits, one per rate
    localparam logic [7:0]  RATE_9600       = 8'h02;
    localparam logic [7:0]  RATE_19200      = 8'h04;
    localparam logic [7:0]  RATE_38400      = 8'h08;
    localparam logic [7:0]  RATE_57600      = 8'h10;
    localparam logic [7:0]  RATE_115200     = 8'h20;
    localparam logic [7:0]  RATE_CAP_MASK   = 8'h3e;
    localparam logic [7:0]  RATE_DEFAULT    = RATE_9600;
    // local parameter answers
    localparam logic [7:0]  PARAM_TURN      = 8'h01;
    localparam logic [7:0]  PARAM_WINDOW    = 8'h01;
    localparam logic [7:0]  PARAM_DISC      = 8'h01;
    // received frame kinds
    localparam logic [2:0]  RX_POLL         = 3'h1;
    localparam logic [2:0]  RX_ID           = 3'h2;
    localparam logic [2:0]  RX_PARAM        = 3'h3;
    localparam logic [2:0]  RX_QUERY        = 3'h4;
    localparam logic [2:0]  RX_CONNECT      = 3'h5;
    localparam logic [2:0]  RX_CLOSE        = 3'h6;
    localparam logic [2:0]  RX_DATA         = 3'h7;
    // transmitted reply kinds
    localparam logic [2:0]  TX_SLOT         = 3'h1;
    localparam logic [2:0]  TX_PARAM        = 3'h2;
    localparam logic [2:0]  TX_ANSWER       = 3'h3;
    localparam logic [2:0]  TX_CONFIRM      = 3'h4;
    localparam logic [2:0]  TX_KEEP         = 3'h5;
    // query subjects and answers
    localparam logic [1:0]  Q_NAME          = 2'h0;
    localparam logic [1:0]  Q_ADDR          = 2'h1;
    localparam logic [1:0]  Q_CAPS          = 2'h2;
    localparam logic [7:0]  CLASS_MODEM     = 8'h4d;
    localparam logic [7:0]  SERVICE_ADDR    = 8'h01;
    localparam logic [7:0]  SERVICE_NAME    = 8'h43;

    typedef enum logic [1:0] {
        ST_DISC_POLL  = 2'b00,
        ST_LINK_INIT  = 2'b01,
        ST_RESOURCE   = 2'b11,
        ST_CONNECTED  = 2'b10
    } irsl_state_e;
endpackage

// file: rtl/irsl_answer_rom.sv
// irsl_answer_rom: answer table for information-service queries
// assumes one query per cycle at most; data appear one cycle after the request
`timescale 1ns/1ps
module irsl_answer_rom
    import irsl_pkg::*;
(
    // clock
    input  wire logic       clock,
    // lookup
    input  wire logic [1:0] subject,
    output logic      [7:0] answer
);
    typedef struct packed {
        logic [7:0] data;
    } irsl_rom_s;

    irsl_rom_s st_reg;
    irsl_rom_s st_next;

    always_comb
    begin
        st_next = st_reg;
        case (subject)
            Q_NAME:  st_next.data = SERVICE_NAME;
            Q_ADDR:  st_next.data = SERVICE_ADDR;
            Q_CAPS:  st_next.data = CLASS_MODEM;
            default: st_next.data = CLASS_MODEM;
        endcase
    end

    always_ff @(posedge clock)
    begin
        st_reg <= st_next;
    end

    assign answer = st_reg.data;
endmodule

// file: sim/irsl_frame_model.sv
// irsl_frame_model: frame layer and remote primary facing the link setup block
// assumes the bench paces frames and gives one random stall bit per cycle
`timescale 1ns/1ps
module irsl_frame_model
    import irsl_pkg::*;
(
    // clock and stall control
    input  wire logic        clock,
    input  wire logic        slow,
    // decoded frames towards the block
    output logic             rx_valid,
    output logic      [2:0]  rx_kind,
    output logic      [3:0]  rx_slot,
    output logic      [7:0]  rx_rate,
    output logic      [1:0]  rx_subject,
    output logic             rx_busy,
    // reply acceptance
    output logic             tx_ready
);
    assign tx_ready = !slow;

    initial
    begin
        rx_valid   = 1'b0;
        rx_busy    = 1'b0;
        rx_kind    = 3'h0;
        rx_slot    = 4'h0;
        rx_rate    = 8'h00;
        rx_subject = 2'h0;
    end

    // receiver busy first, so a pending reply must wait
    task automatic send(input logic [2:0] kind, input logic [3:0] slot, input logic [7:0] rate,
                        input logic [1:0] subj);
        rx_busy = 1'b1;
        repeat (3) @(posedge clock);
        #2;
        rx_busy    = 1'b0;
        rx_valid   = 1'b1;
        rx_kind    = kind;
        rx_slot    = slot;
        rx_rate    = rate;
        rx_subject = subj;
        @(posedge clock);
        #2;
        // fields no longer qualified: show garbage, not the old value
        rx_valid   = 1'b0;
        rx_kind    = ~kind;
        rx_slot    = ~slot;
        rx_rate    = ~rate;
        rx_subject = ~subj;
    endtask
endmodule

// file: sim/irsl_link_setup_bench.sv
// irsl_link_setup_bench: self-checking bench for the link setup block
// assumes the frame model above; short idle timeout for a fast run
`timescale 1ns/1ps
module irsl_link_setup_bench;
    import irsl_pkg::*;
    localparam int unsigned TMO = 100;
    logic        clock = 1'b0;
    logic        rst   = 1'b1;
    logic        slow  = 1'b0;
    logic        conn_exp = 1'b0;
    logic        rx_valid, rx_busy, tx_valid, tx_ready, connected, cts;
    logic [2:0]  rx_kind, tx_kind;
    logic [3:0]  rx_slot;
    logic [1:0]  rx_subject;
    logic [7:0]  rx_rate, tx_rate, tx_turn, tx_window, tx_disc, tx_answer, link_rate;
    logic [31:0] seed = 32'h0000000a;
    logic [10:0] expq[$];
    logic [10:0] e;
    int          errors = 0;
    int          checks = 0;

    always #25 clock = ~clock;

    irsl_frame_model irsl_frame_model_i (.clock(clock), .slow(slow), .rx_valid(rx_valid),
        .rx_kind(rx_kind), .rx_slot(rx_slot), .rx_rate(rx_rate), .rx_subject(rx_subject),
        .rx_busy(rx_busy), .tx_ready(tx_ready));

    irsl_link_setup #(.TIMEOUT_CYC(TMO), .LOCAL_RATES(RATE_CAP_MASK)) irsl_link_setup_i (
        .clock(clock), .rst(rst), .rx_valid(rx_valid), .rx_kind(rx_kind), .rx_slot(rx_slot),
        .rx_rate(rx_rate), .rx_subject(rx_subject), .rx_busy(rx_busy), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_kind(tx_kind), .tx_rate(tx_rate), .tx_turn(tx_turn),
        .tx_window(tx_window), .tx_disc(tx_disc), .tx_answer(tx_answer), .link_rate(link_rate),
        .connected(connected), .cts(cts));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // random stall of the reply path every cycle
    task automatic cyc(input int n);
        repeat (n)
        begin
            @(posedge clock);
            #2;
            seed = xs(seed);
            slow = seed[3];
        end
    endtask

    // one frame; a reply note goes in the queue, then wait until it is taken
    task automatic frame(input logic [2:0] k, input logic [3:0] sl, input logic [7:0] r,
                         input logic [1:0] sb, input logic rep, input logic [10:0] ex);
        int n;
        n = 0;
        if (rep)
            expq.push_back(ex);
        irsl_frame_model_i.send(k, sl, r, sb);
        while (expq.size() != 0 && n < 60)
        begin
            cyc(1);
            n++;
        end
        if (expq.size() != 0)
            check("reply missing", 16'(expq.size()), 16'h0);
        expq.delete();
        cyc(2);
    endtask

    // reply watcher: settled values, taken at the next edge
    always @(negedge clock)
    begin
        if (!rst && rx_busy === 1'b1)
            check("tx_valid while busy", 16'(tx_valid), 16'h0);
        if (!rst && !conn_exp)
            check("cts inhibit", 16'(cts), 16'h1);
        if (!rst && tx_valid === 1'b1 && tx_ready === 1'b1)
        begin
            if (expq.size() == 0)
                check("unexpected reply", 16'(tx_kind), 16'h0);
            else
            begin
                e = expq.pop_front();
                check("tx_kind", 16'(tx_kind), 16'(e[10:8]));
                if (e[10:8] == TX_PARAM)
                begin
                    check("tx_rate", 16'(tx_rate), 16'(e[7:0]));
                    check("tx_turn_window", {tx_turn, tx_window}, {PARAM_TURN, PARAM_WINDOW});
                    check("tx_disc", 16'(tx_disc), 16'(PARAM_DISC));
                end
                if (e[10:8] == TX_ANSWER)
                    check("tx_answer", 16'(tx_answer), 16'(e[7:0]));
            end
        end
    end

    // polls, identification, parameters, queries, connect
    task automatic connect_seq(input logic [7:0] peer, input logic [7:0] exp_rate);
        int np;
        logic [7:0] ans [3];
        ans = '{SERVICE_NAME, SERVICE_ADDR, CLASS_MODEM};
        np = seed[0] ? 8 : 6;
        for (int i = 0; i < np; i++)
            frame(RX_POLL, 4'(i), 8'h00, 2'h0, i == 2, {TX_SLOT, 8'h00});
        frame(RX_ID, 4'h0, 8'h00, 2'h0, 1'b0, 11'h000);
        check("rate at discovery", 16'(link_rate), 16'(RATE_9600));
        frame(RX_PARAM, 4'h0, peer, 2'h0, 1'b1, {TX_PARAM, RATE_CAP_MASK});
        check("negotiated rate", 16'(link_rate), 16'(exp_rate));
        for (int s = 0; s < 3; s++)
            frame(RX_QUERY, 4'h0, 8'h00, 2'(s), 1'b1, {TX_ANSWER, ans[s]});
        check("connected early", 16'(connected), 16'h0);
        conn_exp = 1'b1;
        frame(RX_CONNECT, 4'h0, 8'h00, 2'h0, 1'b0, 11'h000);
        check("connected cts", {7'h0, connected, 7'h0, cts}, 16'h0100);
    endtask

    initial
    begin
        cyc(16);
        rst = 1'b0;
        cyc(1);
        check("reset state", {cts, connected, tx_valid, 5'h0, link_rate}, {3'b100, 5'h0, RATE_9600});
        // identification and parameters with no slot answer: ignored
        frame(RX_ID, 4'h0, 8'h00, 2'h0, 1'b0, 11'h000);
        frame(RX_PARAM, 4'h0, 8'h3e, 2'h0, 1'b0, 11'h000);
        check("rate unchanged", 16'(link_rate), 16'(RATE_9600));
        connect_seq(RATE_19200, RATE_19200);
        frame(RX_POLL, 4'h0, 8'h00, 2'h0, 1'b1, {TX_KEEP, 8'h00});
        frame(RX_CLOSE, 4'h0, 8'h00, 2'h0, 1'b1, {TX_CONFIRM, 8'h00});
        conn_exp = 1'b0;
        check("after close", {cts, connected, 6'h0, link_rate}, {2'b10, 6'h0, RATE_9600});
        connect_seq(RATE_CAP_MASK, RATE_115200);
        cyc(TMO - 20);
        check("still connected", 16'(connected), 16'h1);
        cyc(40);
        check("idle drop", {cts, connected, 6'h0, link_rate}, {2'b10, 6'h0, RATE_9600});
        conn_exp = 1'b0;
        end_of_test();
    end

    initial
    begin
        #(50 * 20000);
        errors++;
        end_of_test();
    end
endmodule
